// file: twmr_pkg.sv
// Package: register map, field positions, status codes and timing for the two-wire master receiver
package twmr_pkg;
    // Register word offsets (byte addresses on the Avalon-MM bus)
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_STATUS  = 4'h4;
    localparam logic [3:0] OFF_DATA    = 4'h8;
    // Control field positions
    localparam int CB_FLAG  = 7;
    localparam int CB_ACK   = 6;
    localparam int CB_STA   = 5;
    localparam int CB_STO   = 4;
    localparam int CB_WCOL  = 3;
    localparam int CB_EN    = 2;
    localparam int CB_IE    = 0;
    // Status codes, prescaler bits read as zero
    localparam logic [7:0] ST_IDLE     = 8'hF8;
    localparam logic [7:0] ST_START    = 8'h08;
    localparam logic [7:0] ST_RSTART   = 8'h10;
    localparam logic [7:0] ST_ARB_LOST = 8'h38;
    localparam logic [7:0] ST_AR_ACK   = 8'h40;
    localparam logic [7:0] ST_AR_NACK  = 8'h48;
    localparam logic [7:0] ST_DR_ACK   = 8'h50;
    localparam logic [7:0] ST_DR_NACK  = 8'h58;
    localparam logic [7:0] ST_MT_MODE  = 8'h18;
    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] DATA_RST    = 8'hFF;
    // Bus timing: one quarter of the bus bit period
    localparam int CLK_MHZ        = 200;
    localparam int QUARTER_NS     = 1250;
    localparam int QUARTER_CYCLES = (QUARTER_NS * CLK_MHZ) / 1000;
    localparam logic [9:0] QUARTER_LAST = 10'(QUARTER_CYCLES - 1);
    // Bus pins carried together
    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } twmr_pins_t;
endpackage

// file: twmr_top.sv
// Two-wire master receiver with an Avalon-MM register slave
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
// Contract
// - Flag+start+enable write: start once bus free
// - After START set flag, status 08
// - Read bit selects receiver, write bit transmitter
// - Writing one clears flag; transfer resumes
// - Address acked: status 40, 48 or 38
// - Received byte held in data register
// - Next byte acked per ack enable
// - Byte received with ACK: status 50
// - Byte received with NACK: status 58
// - Stop request sends STOP, clears itself
// - Start and stop: STOP then START
// - Start request: repeated START, status 10
// - In 10 send address; write switches mode
// - In 38 release bus or restart; restart keeps SCL held low in S_WAIT_FREE, which then never ends
// - In 48/58 start gives repeated START
// - In 08/10 send address, sample ACK
// - Data write with flag low: collision
module twmr_top (
    // System
    input  wire logic        clock,
    input  wire logic        arst_n,
    // Avalon-MM slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Two-wire bus, open drain
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             scl_out,
    output logic             scl_oe,
    output logic             sda_out,
    output logic             sda_oe
);
    typedef enum logic [3:0] {S_IDLE, S_WAIT_FREE, S_START, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK,
                              S_HOLD, S_STOP, S_RSTART, S_FOLLOW} twmr_state_t;

    twmr_state_t       state_reg;
    logic [7:0]        ctrl_reg;
    logic [7:0]        status_reg;
    logic [7:0]        data_reg;
    logic [7:0]        shift_reg;
    logic [9:0]        tick_reg;
    logic [1:0]        phase_reg;
    logic [2:0]        bit_reg;
    logic              rx_mode_reg;
    logic              busy_bus_reg;
    logic [1:0]        scl_sync_reg;
    logic [1:0]        sda_sync_reg;
    logic              sda_last_reg;
    twmr_pkg::twmr_pins_t pins_reg;
    logic              ack_pend_reg;
    logic              wait_reg;
    logic              flag_set;
    logic              stop_done;
    logic              quarter;
    logic              ctrl_wr;
    logic              clr_flag;
    logic              sda_s;
    logic              scl_s;

    assign sda_s    = sda_sync_reg[1];
    assign scl_s    = scl_sync_reg[1];
    assign ctrl_wr  = write && !wait_reg && address == twmr_pkg::OFF_CONTROL;
    assign clr_flag = ctrl_wr && writedata[twmr_pkg::CB_FLAG] && writedata[twmr_pkg::CB_EN];
    assign quarter  = tick_reg == twmr_pkg::QUARTER_LAST;

    // Two-stage synchronisers for the bus pins
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            sda_last_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            sda_last_reg <= sda_s;
        end
    end

    // Bus busy tracking from every START and STOP seen on the bus, our own included
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            busy_bus_reg <= 1'b0;
        else if (scl_s && sda_last_reg && !sda_s)
            busy_bus_reg <= 1'b1;
        else if (scl_s && !sda_last_reg && sda_s)
            busy_bus_reg <= 1'b0;
    end

    // Bus slave answers every access with one wait cycle
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            wait_reg <= 1'b1;
        else
            wait_reg <= !((read || write) && wait_reg);
    end

    // Read data mux; unmapped offsets read zero
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            readdata <= 32'h0000_0000;
        else if (read && wait_reg)
        begin
            case (address)
                twmr_pkg::OFF_CONTROL: readdata <= {24'h000000, ctrl_reg};
                twmr_pkg::OFF_STATUS:  readdata <= {24'h000000, status_reg};
                twmr_pkg::OFF_DATA:    readdata <= {24'h000000, data_reg};
                default:               readdata <= 32'h0000_0000;
            endcase
        end
    end
    assign waitrequest = wait_reg;

    // Control register: flag set by hardware wins over software clear
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_reg <= twmr_pkg::CONTROL_RST;
        else
        begin
            if (ctrl_wr)
            begin
                ctrl_reg[twmr_pkg::CB_ACK] <= writedata[twmr_pkg::CB_ACK];
                ctrl_reg[twmr_pkg::CB_STA] <= writedata[twmr_pkg::CB_STA];
                ctrl_reg[twmr_pkg::CB_STO] <= writedata[twmr_pkg::CB_STO];
                ctrl_reg[twmr_pkg::CB_EN]  <= writedata[twmr_pkg::CB_EN];
                ctrl_reg[twmr_pkg::CB_IE]  <= writedata[twmr_pkg::CB_IE];
                if (writedata[twmr_pkg::CB_FLAG])
                begin
                    ctrl_reg[twmr_pkg::CB_FLAG] <= 1'b0;
                    ctrl_reg[twmr_pkg::CB_WCOL] <= 1'b0;
                end
            end
            if (write && !wait_reg && address == twmr_pkg::OFF_DATA && !ctrl_reg[twmr_pkg::CB_FLAG])
                ctrl_reg[twmr_pkg::CB_WCOL] <= 1'b1;
            if (stop_done)
                ctrl_reg[twmr_pkg::CB_STO] <= 1'b0;
            if (flag_set)
                ctrl_reg[twmr_pkg::CB_FLAG] <= 1'b1;
        end
    end

    // Quarter-period tick generator
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            tick_reg <= 10'h000;
        else if (quarter || state_reg == S_IDLE || state_reg == S_HOLD)
            tick_reg <= 10'h000;
        else
            tick_reg <= tick_reg + 10'h001;
    end

    // Lost arbitration must raise the flag too, or the hold state would wait forever
    assign flag_set  = quarter && ((phase_reg == 2'h3 &&
                       (state_reg == S_START || state_reg == S_RSTART || state_reg == S_ADDR_ACK ||
                        state_reg == S_RX_ACK)) ||
                       (state_reg == S_ADDR && phase_reg == 2'h1 && sda_s != shift_reg[7]));
    assign stop_done = quarter && phase_reg == 2'h3 && state_reg == S_STOP;

    // Main sequencer; each bit is four quarter phases, SCL high in phases 1 and 2
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg   <= S_IDLE;
            status_reg  <= twmr_pkg::ST_IDLE;
            data_reg    <= twmr_pkg::DATA_RST;
            shift_reg   <= 8'h00;
            phase_reg   <= 2'h0;
            bit_reg     <= 3'h7;
            rx_mode_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
            pins_reg    <= '0;
        end
        else
        begin
            if (write && !wait_reg && address == twmr_pkg::OFF_DATA && ctrl_reg[twmr_pkg::CB_FLAG])
                data_reg <= writedata[7:0];
            if (quarter)
                phase_reg <= phase_reg + 2'h1;
            case (state_reg)
                S_IDLE:
                begin
                    pins_reg <= '0;
                    if (clr_flag && writedata[twmr_pkg::CB_STA])
                        state_reg <= S_WAIT_FREE;
                end
                S_WAIT_FREE:
                    if (!busy_bus_reg && scl_s && sda_s)
                    begin
                        state_reg <= S_START;
                        phase_reg <= 2'h0;
                    end
                S_START, S_RSTART:
                begin
                    // SDA falls while SCL high, then SCL is pulled low
                    if (phase_reg == 2'h0 && state_reg == S_RSTART)
                        pins_reg <= '{scl_oe: 1'b1, sda_oe: 1'b0};
                    if (phase_reg == 2'h2)
                        pins_reg.sda_oe <= 1'b1;
                    if (phase_reg == 2'h1 && state_reg == S_RSTART)
                        pins_reg.scl_oe <= 1'b0;
                    if (quarter && phase_reg == 2'h3)
                    begin
                        pins_reg.scl_oe <= 1'b1;
                        status_reg <= (state_reg == S_START) ? twmr_pkg::ST_START : twmr_pkg::ST_RSTART;
                        state_reg  <= S_HOLD;
                    end
                end
                S_HOLD:
                begin
                    pins_reg.scl_oe <= 1'b1;
                    phase_reg <= 2'h0;
                    if (clr_flag)
                    begin
                        bit_reg <= 3'h7;
                        if (writedata[twmr_pkg::CB_STO])
                            state_reg <= S_STOP;
                        else if (status_reg == twmr_pkg::ST_ARB_LOST)
                            state_reg <= writedata[twmr_pkg::CB_STA] ? S_WAIT_FREE : S_IDLE;
                        else if (writedata[twmr_pkg::CB_STA])
                            state_reg <= S_RSTART;
                        else if (status_reg == twmr_pkg::ST_START || status_reg == twmr_pkg::ST_RSTART)
                        begin
                            shift_reg   <= data_reg;
                            rx_mode_reg <= data_reg[0];
                            state_reg   <= S_ADDR;
                        end
                        else if (status_reg == twmr_pkg::ST_AR_ACK || status_reg == twmr_pkg::ST_DR_ACK)
                        begin
                            ack_pend_reg <= writedata[twmr_pkg::CB_ACK];
                            state_reg    <= S_RX;
                        end
                        else
                            state_reg <= S_IDLE;
                    end
                end
                S_ADDR:
                begin
                    // Drive address bits MSB first, low SCL in phases 0 and 3
                    pins_reg.scl_oe <= (phase_reg == 2'h0 || phase_reg == 2'h3);
                    pins_reg.sda_oe <= !shift_reg[7];
                    if (quarter && phase_reg == 2'h1 && sda_s != shift_reg[7])
                    begin
                        status_reg <= twmr_pkg::ST_ARB_LOST;
                        pins_reg   <= '0;
                        state_reg  <= S_HOLD;
                    end
                    else if (quarter && phase_reg == 2'h3)
                    begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        bit_reg   <= bit_reg - 3'h1;
                        if (bit_reg == 3'h0)
                            state_reg <= S_ADDR_ACK;
                    end
                end
                S_ADDR_ACK:
                begin
                    pins_reg.sda_oe <= 1'b0;
                    pins_reg.scl_oe <= (phase_reg == 2'h0 || phase_reg == 2'h3);
                    if (quarter && phase_reg == 2'h1)
                    begin
                        if (!rx_mode_reg)
                            status_reg <= twmr_pkg::ST_MT_MODE;
                        else
                            status_reg <= sda_s ? twmr_pkg::ST_AR_NACK : twmr_pkg::ST_AR_ACK;
                    end
                    if (quarter && phase_reg == 2'h3)
                        state_reg <= S_HOLD;
                end
                S_RX:
                begin
                    pins_reg.sda_oe <= 1'b0;
                    pins_reg.scl_oe <= (phase_reg == 2'h0 || phase_reg == 2'h3);
                    if (quarter && phase_reg == 2'h1)
                        shift_reg <= {shift_reg[6:0], sda_s};
                    if (quarter && phase_reg == 2'h3)
                    begin
                        bit_reg <= bit_reg - 3'h1;
                        if (bit_reg == 3'h0)
                            state_reg <= S_RX_ACK;
                    end
                end
                S_RX_ACK:
                begin
                    pins_reg.sda_oe <= ack_pend_reg;
                    pins_reg.scl_oe <= (phase_reg == 2'h0 || phase_reg == 2'h3);
                    if (quarter && phase_reg == 2'h3)
                    begin
                        data_reg   <= shift_reg;
                        status_reg <= ack_pend_reg ? twmr_pkg::ST_DR_ACK : twmr_pkg::ST_DR_NACK;
                        state_reg  <= S_HOLD;
                    end
                end
                S_STOP:
                begin
                    // SDA low, SCL released, then SDA released while SCL high
                    pins_reg.scl_oe <= (phase_reg == 2'h0);
                    pins_reg.sda_oe <= (phase_reg != 2'h3);
                    if (quarter && phase_reg == 2'h3)
                    begin
                        status_reg <= twmr_pkg::ST_IDLE;
                        state_reg  <= ctrl_reg[twmr_pkg::CB_STA] ? S_FOLLOW : S_IDLE;
                    end
                end
                S_FOLLOW:
                    if (quarter)
                        state_reg <= S_WAIT_FREE;
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end

    // Open-drain outputs: drive low whenever enabled
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            scl_oe  <= pins_reg.scl_oe;
            sda_oe  <= pins_reg.sda_oe;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // Status result follows START within one bit time
    start_status_a: assert property (@(posedge clock) disable iff (!arst_n)
        (state_reg == S_START && quarter && phase_reg == 2'h3) |=> status_reg == twmr_pkg::ST_START && ctrl_reg[7])
        else $error("start status missing");
    // Flag holds the clock low
    hold_scl_a: assert property (@(posedge clock) disable iff (!arst_n)
        (state_reg == S_HOLD) |-> ##2 (scl_oe || state_reg != S_HOLD))
        else $error("bus clock not stretched");
    // Collision bit rises on early data write
    wr_collision_a: assert property (@(posedge clock) disable iff (!arst_n)
        (write && !wait_reg && address == twmr_pkg::OFF_DATA && !ctrl_reg[7] && !flag_set) |=> ctrl_reg[3])
        else $error("write collision not flagged");
    // Stop request self clears
    stop_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
        stop_done && !ctrl_wr |=> !ctrl_reg[4])
        else $error("stop request not cleared");
    // Received byte lands with status
    rx_byte_a: assert property (@(posedge clock) disable iff (!arst_n)
        (state_reg == S_RX_ACK && quarter && phase_reg == 2'h3) |=>
        (status_reg == (ack_pend_reg ? twmr_pkg::ST_DR_ACK : twmr_pkg::ST_DR_NACK)) && data_reg == $past(shift_reg))
        else $error("received byte status wrong");
    // Clear write drops the flag
    flag_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
        (clr_flag && !flag_set) |=> !ctrl_reg[7])
        else $error("flag not cleared");
    // Start request leaves idle
    start_req_a: assert property (@(posedge clock) disable iff (!arst_n)
        (state_reg == S_IDLE && clr_flag && writedata[5]) |=> state_reg == S_WAIT_FREE)
        else $error("start not requested");
    // Acknowledge drive follows ack enable
    ack_drive_a: assert property (@(posedge clock) disable iff (!arst_n)
        (state_reg == S_RX_ACK) |=> (pins_reg.sda_oe == $past(ack_pend_reg) || state_reg != S_RX_ACK))
        else $error("ack drive wrong");
endmodule // twmr_top

// file: twmr_slave_model.sv
// Behavioural slave transmitter that answers on the open-drain two-wire bus
`timescale 1ns/10ps
module twmr_slave_model (
    // Wire levels
    input  wire logic       scl,
    input  wire logic       sda,
    // Setup from the bench
    input  wire logic [6:0] own_addr,
    input  wire logic [7:0] first_byte,
    // Data line pull-down and observation
    output logic            sda_oe,
    output int              stop_cnt
);
    logic [7:0] shift;
    logic [7:0] cur;
    logic       go;
    int         i;
    int         k;

    initial sda_oe = 1'b0;
    initial stop_cnt = 0;

    // Data rising while the clock is high ends a frame
    always @(posedge sda)
        if (scl === 1'b1)
            stop_cnt <= stop_cnt + 1;

    // Address, acknowledge, then bytes first_byte, first_byte+1, ... until the master refuses one
    always
    begin
        @(negedge sda iff scl === 1'b1);
        for (i = 0; i < 8; i++)
        begin
            @(posedge scl);
            shift = {shift[6:0], sda};
        end
        @(negedge scl);
        if (shift[7:1] == own_addr)
        begin
            sda_oe = 1'b1;
            @(negedge scl);
            go = shift[0];
            k = 0;
            cur = first_byte;
            // Release after the acknowledge unless a read follows
            sda_oe = go & ~cur[7];
            while (go)
            begin
                for (i = 6; i >= 0; i--)
                begin
                    @(negedge scl);
                    sda_oe = ~cur[i];
                end
                @(negedge scl);
                sda_oe = 1'b0;
                @(posedge scl);
                go = ~sda;
                k++;
                cur = first_byte + 8'(k);
                if (go)
                begin
                    @(negedge scl);
                    sda_oe = ~cur[7];
                end
            end
        end
    end
endmodule // twmr_slave_model

// file: tb.sv
// Testbench: register-driven read transfers against a slave transmitter model
`timescale 1ns/10ps
module tb;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest, scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe, slv_oe;
    logic [6:0]  own_addr = 7'h00;
    logic [7:0]  first_byte = 8'h00;
    logic [7:0]  rd;
    logic [31:0] seed = 32'h172CDFDE;
    int          stop_cnt, stops;
    int          fails = 0;
    int          n_compared = 0;
    // Control words keep the enable set and the reserved bit clear
    localparam logic [7:0] C_GO = 8'h84;
    localparam logic [7:0] C_ACK = 8'hC4;
    localparam logic [7:0] C_STA = 8'hA4;
    localparam logic [7:0] C_STO = 8'h94;
    localparam logic [7:0] C_BOTH = 8'hB4;

    always #2.5 clock = ~clock;

    // Open-drain wires with pull-ups
    assign scl_in = ~scl_oe;
    assign sda_in = ~(sda_oe | slv_oe);

    twmr_top u_dut (.clock(clock), .arst_n(arst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl_in),
        .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

    twmr_slave_model u_slave (.scl(scl_in), .sda(sda_in), .own_addr(own_addr), .first_byte(first_byte),
        .sda_oe(slv_oe), .stop_cnt(stop_cnt));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // One Avalon access; the request stands until waitrequest is sampled low at a rising edge
    task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge clock);
        address <= a;
        write <= we;
        read <= ~we;
        writedata <= {24'h0, d};
        for (n = 0; n < 50; n++)
        begin
            @(posedge clock);
            if (waitrequest === 1'b0)
                break;
        end
        if (n == 50)
        begin
            fails++;
            end_of_test();
        end
        // Read data stand at the edge that sees waitrequest low; release right after it
        rd = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
    endtask

    // Poll one control bit; a byte on the bus takes about 9000 cycles
    task automatic wait_ctrl(input int b, input logic v);
        int k;
        for (k = 0; k < 2000; k++)
        begin
            bus(1'b0, twmr_pkg::OFF_CONTROL, 8'h00);
            if (rd[b] === v)
                break;
            repeat (8) @(posedge clock);
        end
        if (k == 2000)
        begin
            fails++;
            end_of_test();
        end
    endtask

    // Status is decoded with the prescaler bits masked off
    task automatic status_is(input logic [7:0] exp);
        bus(1'b0, twmr_pkg::OFF_STATUS, 8'h00);
        check("status", rd & 8'hF8, exp);
    endtask

    task automatic step(input logic [7:0] ctrl, input logic [7:0] exp);
        bus(1'b1, twmr_pkg::OFF_CONTROL, ctrl);
        wait_ctrl(twmr_pkg::CB_FLAG, 1'b1);
        status_is(exp);
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        void'(xs());
        own_addr <= seed[6:0];
        first_byte <= seed[15:8];
        // Reset values and an unmapped place
        bus(1'b0, twmr_pkg::OFF_CONTROL, 8'h00);
        check("control_reset", rd, twmr_pkg::CONTROL_RST);
        status_is(twmr_pkg::ST_IDLE);
        bus(1'b0, twmr_pkg::OFF_DATA, 8'h00);
        check("data_reset", rd, twmr_pkg::DATA_RST);
        bus(1'b0, 4'hC, 8'h00);
        check("unmapped", rd, 8'h00);
        $display("test reset done");
        // START on a free bus, clock held low while the flag stands
        step(C_STA, twmr_pkg::ST_START);
        @(negedge clock);
        check("scl_held", {7'h0, scl_oe}, 8'h01);
        check("pins_drive_low", {6'h0, scl_out, sda_out}, 8'h00);
        // Read address; a data write while the flag is low collides
        bus(1'b1, twmr_pkg::OFF_DATA, {own_addr, 1'b1});
        bus(1'b1, twmr_pkg::OFF_CONTROL, C_GO);
        bus(1'b0, twmr_pkg::OFF_CONTROL, 8'h00);
        check("flag_cleared", {7'h0, rd[7]}, 8'h00);
        bus(1'b1, twmr_pkg::OFF_DATA, seed[23:16]);
        bus(1'b0, twmr_pkg::OFF_CONTROL, 8'h00);
        check("collision", {7'h0, rd[3]}, 8'h01);
        wait_ctrl(twmr_pkg::CB_FLAG, 1'b1);
        status_is(twmr_pkg::ST_AR_ACK);
        $display("test start and address done");
        // Two bytes, the last one refused so the slave stops
        step(C_ACK, twmr_pkg::ST_DR_ACK);
        bus(1'b0, twmr_pkg::OFF_DATA, 8'h00);
        check("byte0", rd, first_byte);
        step(C_GO, twmr_pkg::ST_DR_NACK);
        bus(1'b0, twmr_pkg::OFF_DATA, 8'h00);
        check("byte1", rd, first_byte + 8'h01);
        $display("test receive done");
        // Repeated START, then an address nobody answers
        step(C_STA, twmr_pkg::ST_RSTART);
        bus(1'b1, twmr_pkg::OFF_DATA, {own_addr ^ 7'h2A, 1'b1});
        step(C_GO, twmr_pkg::ST_AR_NACK);
        // STOP followed by START
        stops = stop_cnt;
        step(C_BOTH, twmr_pkg::ST_START);
        bus(1'b0, twmr_pkg::OFF_CONTROL, 8'h00);
        check("stop_bit", {7'h0, rd[4]}, 8'h00);
        check("stop_seen", 8'(stop_cnt - stops), 8'h01);
        $display("test restart done");
        // Write address hands over to the transmitter, then STOP frees the bus
        bus(1'b1, twmr_pkg::OFF_DATA, {own_addr, 1'b0});
        step(C_GO, twmr_pkg::ST_MT_MODE);
        stops = stop_cnt;
        bus(1'b1, twmr_pkg::OFF_CONTROL, C_STO);
        wait_ctrl(twmr_pkg::CB_STO, 1'b0);
        repeat (1000) @(posedge clock);
        check("stop_sent", 8'(stop_cnt - stops), 8'h01);
        check("bus_free", {6'h0, scl_in, sda_in}, 8'h03);
        $display("test stop done");
        end_of_test();
    end
endmodule // tb
